// ==== rtl/tcc_timer.sv ====
`timescale 1ns/1ps
module tcc_timer
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire tcc_pkg::tcc_ctrl_t ctrl,
   input wire logic oneshot_trig,
   input wire logic wr_a,
   input wire logic wr_b,
   input wire logic [15:0] wdata,
   input wire logic rd_a,
   input wire logic rd_b,
   input wire logic overflow_clr,
   input wire logic capture_input_a,
   input wire logic shared_port_pin_in,
   output logic shared_port_pin_out_r,
   output logic shared_port_pin_oe_r,
   output logic [15:0] rdata_r,
   output logic [15:0] count_value_r,
   output logic match_irq_a_r,
   output logic match_irq_b_r,
   output logic overflow_flag_r
);
   logic [1:0] mode;
   logic run;
   logic [tcc_pkg::DIV_W-1:0] div_r;
   logic [tcc_pkg::DIV_W-1:0] div_mask;
   logic tick;
   logic [tcc_pkg::SYNC_N-1:0] pin_raw;
   logic [tcc_pkg::SYNC_N-1:0] pin_rise;
   logic [tcc_pkg::SYNC_N-1:0] pin_fall;
   logic edge_a_ok;
   logic edge_b_ok;
   logic [15:0] compare_capture_reg_a_r;
   logic [15:0] compare_capture_reg_b_r;
   logic wrapped_r;
   logic hit_a;
   logic hit_b;
   logic clr_now;
   logic clr_match;
   logic wrap_now;
   logic [15:0] count_nxt;

   assign mode = {ctrl.op_mode_bit_high, ctrl.op_mode_bit_low};
   assign run = (mode != tcc_pkg::MODE_STOP);

   // count tick divider: sel 0..3 gives every 1, 2, 4 or 8 system clocks
   always_comb
   begin
      case (ctrl.prescale_sel)
         2'h0: div_mask = 3'h0;
         2'h1: div_mask = 3'h1;
         2'h2: div_mask = 3'h3;
         default: div_mask = 3'h7;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         div_r <= '0;
      else
         div_r <= div_r + 3'h1;
   end

   assign tick = ((div_r & div_mask) == 3'h0);

   // input a on index 0, shared pin on index 1
   assign pin_raw = {shared_port_pin_in, capture_input_a};

   genvar gi;
   generate
      for (gi = 0; gi < tcc_pkg::SYNC_N; gi++)
      begin : g_sync
         tcc_pin_sync u_sync
         (
            .sys_clk(sys_clk),
            .rst(rst),
            .pin_in(pin_raw[gi]),
            .level_r(),
            .rise(pin_rise[gi]),
            .fall(pin_fall[gi])
         );
      end
   endgenerate

   assign edge_a_ok = run && (ctrl.edge_rise_a ? pin_rise[0] : pin_fall[0]);
   // pin used as output never feeds the capture edge path
   assign edge_b_ok = run && !ctrl.pin_is_output && (ctrl.edge_rise_b ? pin_rise[1] : pin_fall[1]);

   // a zero compare value only matches once the count has wrapped
   assign hit_a = run && tick && !ctrl.cap_mode_a && (count_value_r == compare_capture_reg_a_r)
                  && ((compare_capture_reg_a_r != tcc_pkg::COUNT_ZERO) || wrapped_r);
   assign hit_b = run && tick && !ctrl.cap_mode_b && (count_value_r == compare_capture_reg_b_r)
                  && ((compare_capture_reg_b_r != tcc_pkg::COUNT_ZERO) || wrapped_r);

   assign clr_match = (mode == tcc_pkg::MODE_CLR_MATCH) && tick && !ctrl.cap_mode_a
                      && (count_value_r == compare_capture_reg_a_r);
   assign clr_now = oneshot_trig
                    || ((mode == tcc_pkg::MODE_CLR_EDGE) && edge_a_ok)
                    || clr_match;
   // a match clear at ffffh still lands on 0000h, so it counts as the wrap
   assign wrap_now = run && tick && (count_value_r == tcc_pkg::COUNT_MAX) && (!clr_now || clr_match);

   always_comb
   begin
      count_nxt = count_value_r;
      if (!run)
         count_nxt = tcc_pkg::COUNT_ZERO;
      else if (clr_now)
         count_nxt = tcc_pkg::COUNT_ZERO;
      else if (tick)
         count_nxt = count_value_r + 16'h0001;
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         count_value_r <= tcc_pkg::COUNT_ZERO;
      else
         count_value_r <= count_nxt;
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         wrapped_r <= 1'b0;
      else if (!run)
         wrapped_r <= 1'b0;
      else if (wrap_now)
         wrapped_r <= 1'b1;
   end

   // register a: compare value from software or capture on input b edge;
   // writes while counting are not blocked, keeping them off is up to software
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         compare_capture_reg_a_r <= tcc_pkg::CMP_RESET;
      else if (ctrl.cap_mode_a && edge_b_ok)
         compare_capture_reg_a_r <= count_value_r;
      else if (wr_a)
         compare_capture_reg_a_r <= wdata;
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         compare_capture_reg_b_r <= tcc_pkg::CMP_RESET;
      else if (ctrl.cap_mode_b && edge_a_ok)
         compare_capture_reg_b_r <= count_value_r;
      else if (wr_b)
         compare_capture_reg_b_r <= wdata;
   end

   // a read meeting a capture returns the pre-capture value
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         rdata_r <= tcc_pkg::CMP_RESET;
      else if (rd_a)
         rdata_r <= compare_capture_reg_a_r;
      else if (rd_b)
         rdata_r <= compare_capture_reg_b_r;
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         match_irq_a_r <= 1'b0;
         match_irq_b_r <= 1'b0;
      end
      else
      begin
         match_irq_a_r <= hit_a || edge_b_ok || (run && oneshot_trig);
         match_irq_b_r <= hit_b || edge_a_ok || (run && oneshot_trig);
      end
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         overflow_flag_r <= 1'b0;
      else if (wrap_now)
         overflow_flag_r <= 1'b1;
      else if (overflow_clr)
         overflow_flag_r <= 1'b0;
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         shared_port_pin_out_r <= 1'b0;
         shared_port_pin_oe_r <= 1'b0;
      end
      else
      begin
         shared_port_pin_oe_r <= ctrl.pin_is_output;
         if (!run)
            shared_port_pin_out_r <= 1'b0;
         else if (ctrl.pin_is_output && (hit_a || hit_b))
            shared_port_pin_out_r <= !shared_port_pin_out_r;
      end
   end

   property p_zero_a;
      @(posedge sys_clk) disable iff (rst)
      (run && tick && !clr_now && !ctrl.cap_mode_a && compare_capture_reg_a_r == 16'h0000 && wrapped_r
       && count_value_r == 16'h0000) |=> (match_irq_a_r && count_value_r == 16'h0001);
   endproperty
   a_zero_a: assert property (p_zero_a) else $error("no irq a at 0000h to 0001h");

   property p_edge_b_irq_a;
      @(posedge sys_clk) disable iff (rst)
      (edge_b_ok && ctrl.cap_mode_a) |=> (match_irq_a_r && compare_capture_reg_a_r == $past(count_value_r));
   endproperty
   a_edge_b_irq_a: assert property (p_edge_b_irq_a) else $error("capture into a or irq a missing");

   property p_oneshot;
      @(posedge sys_clk) disable iff (rst)
      (run && oneshot_trig && $stable(mode)) |=> (match_irq_a_r && match_irq_b_r && count_value_r == 16'h0000);
   endproperty
   a_oneshot: assert property (p_oneshot) else $error("one-shot clear did not fire both irqs");

   property p_pin_exclusive;
      @(posedge sys_clk) disable iff (rst)
      ctrl.pin_is_output |-> (!edge_b_ok ##1 shared_port_pin_oe_r);
   endproperty
   a_pin_exclusive: assert property (p_pin_exclusive) else $error("shared pin used both ways");

   property p_zero_b;
      @(posedge sys_clk) disable iff (rst)
      (run && tick && !ctrl.cap_mode_b && compare_capture_reg_b_r == 16'h0000 && wrapped_r
       && count_value_r == 16'h0000) |=> match_irq_b_r;
   endproperty
   a_zero_b: assert property (p_zero_b) else $error("no irq b at 0000h to 0001h");

   property p_edge_a_irq_b;
      @(posedge sys_clk) disable iff (rst)
      edge_a_ok |=> match_irq_b_r;
   endproperty
   a_edge_a_irq_b: assert property (p_edge_a_irq_b) else $error("edge on input a gave no irq b");

   property p_write_b;
      @(posedge sys_clk) disable iff (rst)
      (wr_b && !(ctrl.cap_mode_b && edge_a_ok)) |=> (compare_capture_reg_b_r == $past(wdata));
   endproperty
   a_write_b: assert property (p_write_b) else $error("write to register b lost");

   property p_stop;
      @(posedge sys_clk) disable iff (rst)
      (!run) |=> (count_value_r == 16'h0000 && !match_irq_a_r && !match_irq_b_r);
   endproperty
   a_stop: assert property (p_stop) else $error("counter active in stop mode");

   property p_start;
      @(posedge sys_clk) disable iff (rst)
      ($rose(run) && tick && !clr_now) |=> (count_value_r == 16'h0001);
   endproperty
   a_start: assert property (p_start) else $error("counter did not start at once");

   property p_overflow;
      @(posedge sys_clk) disable iff (rst)
      wrap_now |=> (overflow_flag_r && count_value_r == 16'h0000);
   endproperty
   a_overflow: assert property (p_overflow) else $error("overflow flag not set on wrap");

   property p_step;
      @(posedge sys_clk) disable iff (rst)
      (run && tick && !clr_now && $stable(mode)) |=> (count_value_r == $past(count_value_r) + 16'h0001);
   endproperty
   a_step: assert property (p_step) else $error("count did not step by one");

   c_wrap: cover property (@(posedge sys_clk) disable iff (rst) wrap_now);
   c_match_clear: cover property (@(posedge sys_clk) disable iff (rst)
      (mode == tcc_pkg::MODE_CLR_MATCH) && hit_a);
   c_capture_a: cover property (@(posedge sys_clk) disable iff (rst) ctrl.cap_mode_a && edge_b_ok);
   c_pin_toggle: cover property (@(posedge sys_clk) disable iff (rst) $rose(shared_port_pin_out_r));
endmodule

// ==== include/tcc_pkg.sv ====
// Function
// - in free-running or clear-on-edge mode with register a at zero, match_irq_a fires as the count steps 0000h to 0001h after a wrap at ffffh.
// - match_irq_a fires on a register a match, on a valid edge of capture input b, or on a one-shot clear.
// - the shared pin is either the capture input b edge source or the timer output, never both at once.
// - a read of a capture register that meets a capture gives undefined read data while the captured value stays correct.
// - a count stop that meets a capture trigger leaves the captured value undefined.
// - with register b at zero, match_irq_b fires as the count steps 0000h to 0001h after a wrap at ffffh.
// - match_irq_b fires on a register b match, on a valid edge of capture input a, or on a one-shot clear.
// - register b accepts writes while counting and later compares use the new value.
// - counting starts as soon as the two mode bits are anything other than both zero.
// - in clear-on-match, clear-on-edge or free-running mode the overflow flag sets when the count wraps ffffh to 0000h.
package tcc_pkg;
   localparam logic [15:0] COUNT_MAX = 16'hffff;
   localparam logic [15:0] COUNT_ZERO = 16'h0000;
   localparam logic [15:0] CMP_RESET = 16'h0000;
   localparam logic [1:0] MODE_STOP = 2'h0;
   localparam logic [1:0] MODE_CLR_EDGE = 2'h1;
   localparam logic [1:0] MODE_FREE = 2'h2;
   localparam logic [1:0] MODE_CLR_MATCH = 2'h3;
   localparam int DIV_W = 3;
   localparam int SYNC_N = 2;

   typedef struct packed {
      logic op_mode_bit_high;
      logic op_mode_bit_low;
      logic cap_mode_a;     // register a captures instead of compares
      logic cap_mode_b;
      logic edge_rise_a;    // 1: rising edge valid, 0: falling edge valid
      logic edge_rise_b;
      logic pin_is_output;  // shared pin drives the timer output
      logic [1:0] prescale_sel;
   } tcc_ctrl_t;
endpackage

// ==== rtl/tcc_pin_sync.sv ====
`timescale 1ns/1ps
// three-stage synchroniser; a level counts once stages two and three agree
module tcc_pin_sync
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic pin_in,
   output logic level_r,
   output logic rise,
   output logic fall
);
   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic agree;

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end
      else
      begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   assign agree = (s2_r == s3_r);

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         level_r <= 1'b0;
      else if (agree)
         level_r <= s3_r;
   end

   assign rise = agree && s3_r && !level_r;
   assign fall = agree && !s3_r && level_r;
endmodule

// ==== dv/tcc_pulse_src.sv ====
`timescale 1ns/1ps
// far-side pulse sources for the two capture inputs
module tcc_pulse_src
(
   input wire logic sys_clk,
   input wire logic go_a,
   input wire logic go_b,
   input wire logic pin_oe,
   input wire logic pin_out,
   output logic cap_a,
   output logic pin_wire
);
   int cnt_a = 0;
   int cnt_b = 0;
   // 8-clock pulses: longer than two ticks plus the synchroniser delay
   always @(posedge sys_clk)
   begin
      cnt_a <= go_a ? 8 : (cnt_a > 0 ? cnt_a - 1 : 0);
      cnt_b <= go_b ? 8 : (cnt_b > 0 ? cnt_b - 1 : 0);
   end
   assign cap_a = cnt_a > 0;
   // the source lets go of the pin while the timer drives it
   assign pin_wire = pin_oe ? pin_out : (cnt_b > 0);
endmodule

// ==== dv/tcc_timer_tb.sv ====
`timescale 1ns/1ps
module tcc_timer_tb;
   logic sys_clk = 0;
   logic rst = 1;
   tcc_pkg::tcc_ctrl_t ctrl = '0;
   logic oneshot_trig = 0, wr_a = 0, wr_b = 0, rd_a = 0, rd_b = 0, overflow_clr = 0, go_a = 0, go_b = 0;
   logic [15:0] wdata = 16'h0000;
   logic cap_a, pin_wire, pin_out, pin_oe, irq_a, irq_b, ovf, seen;
   logic [15:0] rdata, count, t, v;
   int bad_count = 0;
   int check_count = 0;
   initial forever #50 sys_clk = ~sys_clk;
   tcc_timer uut (.sys_clk(sys_clk), .rst(rst), .ctrl(ctrl), .oneshot_trig(oneshot_trig), .wr_a(wr_a),
      .wr_b(wr_b), .wdata(wdata), .rd_a(rd_a), .rd_b(rd_b), .overflow_clr(overflow_clr),
      .capture_input_a(cap_a), .shared_port_pin_in(pin_wire), .shared_port_pin_out_r(pin_out),
      .shared_port_pin_oe_r(pin_oe), .rdata_r(rdata), .count_value_r(count), .match_irq_a_r(irq_a),
      .match_irq_b_r(irq_b), .overflow_flag_r(ovf));
   tcc_pulse_src src (.sys_clk(sys_clk), .go_a(go_a), .go_b(go_b), .pin_oe(pin_oe), .pin_out(pin_out),
      .cap_a(cap_a), .pin_wire(pin_wire));
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      check_count++;
      if (s !== e)
      begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic set_mode(input logic [1:0] m);
      {ctrl.op_mode_bit_high, ctrl.op_mode_bit_low} = m;
      tick(2);
   endtask
   task automatic wr(input logic sel_b, input logic [15:0] d);
      wdata = d;
      wr_a = !sel_b;
      wr_b = sel_b;
      tick(1);
      wr_a = 0;
      wr_b = 0;
   endtask
   task automatic rd(input logic sel_b, output logic [15:0] d);
      rd_a = !sel_b;
      rd_b = sel_b;
      tick(1);
      rd_a = 0;
      rd_b = 0;
      d = rdata;
   endtask
   // returns in the settled cycle of the pulse; a miss ends the run
   task automatic wait_irq(input logic sel_b, input int bound);
      for (int i = 0; i < bound; i++)
      begin
         if ((sel_b ? irq_b : irq_a) === 1'b1)
            return;
         tick(1);
      end
      chk(16'h0000, 16'h0001);
      report_and_stop();
   endtask
   initial
   begin
      tick(3);
      rst = 0;
      tick(1);
      chk({13'h0000, irq_a, irq_b, ovf}, 16'h0000);
      chk(count, 16'h0000);
      $display("test reset done");
      wr(0, 16'h0003);
      {ctrl.op_mode_bit_high, ctrl.op_mode_bit_low} = tcc_pkg::MODE_FREE;
      tick(1);
      wait_irq(0, 20);
      chk(count, 16'h0004);
      set_mode(tcc_pkg::MODE_STOP);
      chk(count, 16'h0000);
      $display("test start stop done");
      wr(1, 16'h0005);
      set_mode(tcc_pkg::MODE_FREE);
      wr(1, 16'h0008);
      wait_irq(1, 30);
      chk(count, 16'h0009);
      set_mode(tcc_pkg::MODE_STOP);
      $display("test b rewrite done");
      wr(0, 16'h0005);
      set_mode(tcc_pkg::MODE_CLR_MATCH);
      wait_irq(0, 20);
      chk(count, 16'h0000);
      tick(5);
      chk({15'h0000, irq_a}, 16'h0000);
      tick(1);
      chk({15'h0000, irq_a}, 16'h0001);
      set_mode(tcc_pkg::MODE_STOP);
      $display("test clear on match done");
      wr(0, 16'h0000);
      wr(1, 16'h0000);
      set_mode(tcc_pkg::MODE_FREE);
      wait_irq(0, 70000);
      chk(count, 16'h0001);
      chk({15'h0000, irq_b}, 16'h0001);
      chk({15'h0000, ovf}, 16'h0001);
      overflow_clr = 1;
      tick(1);
      overflow_clr = 0;
      tick(1);
      chk({15'h0000, ovf}, 16'h0000);
      set_mode(tcc_pkg::MODE_STOP);
      $display("test wrap done");
      ctrl.cap_mode_a = 1;
      ctrl.cap_mode_b = 1;
      ctrl.edge_rise_a = 1;
      ctrl.edge_rise_b = 1;
      set_mode(tcc_pkg::MODE_FREE);
      go_a = 1;
      tick(1);
      go_a = 0;
      wait_irq(1, 12);
      t = count;
      rd(1, v);
      chk(v, t - 16'h0001);
      go_b = 1;
      tick(1);
      go_b = 0;
      wait_irq(0, 12);
      t = count;
      rd(0, v);
      chk(v, t - 16'h0001);
      set_mode(tcc_pkg::MODE_STOP);
      $display("test capture done");
      ctrl.pin_is_output = 1;
      // register b compares again: the output toggles at count 6 and its own edge comes back on the pin
      ctrl.cap_mode_b = 0;
      set_mode(tcc_pkg::MODE_FREE);
      chk({15'h0000, pin_oe}, 16'h0001);
      go_b = 1;
      tick(1);
      go_b = 0;
      seen = 0;
      repeat (14)
      begin
         seen = seen | irq_a;
         tick(1);
      end
      chk({15'h0000, seen}, 16'h0000);
      chk({15'h0000, pin_out}, 16'h0001);
      oneshot_trig = 1;
      tick(1);
      oneshot_trig = 0;
      wait_irq(0, 2);
      chk({15'h0000, irq_b}, 16'h0001);
      $display("test pin and one-shot done");
      report_and_stop();
   end
endmodule
